// ---- hw/tec_pin_sync.sv ----
// Purpose: bring the external count input into the clk domain
// Assumes: pin is fully asynchronous to clk
// Notes: gives the settled level and its one-cycle-old copy for edges
`timescale 1ns/1ps
module tec_pin_sync
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic pinIn,
	output logic level,
	output logic levelPrev
);
	logic meta;

	// two flops before use; first stage feeds only the second
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			meta <= 1'b0;
			level <= 1'b0;
			levelPrev <= 1'b0;
		end
		else if (ce)
		begin
			meta <= pinIn;
			level <= meta;
			levelPrev <= level; // history for edge detection
		end
	end
endmodule

// ---- hw/tec_pkg.sv ----
// Purpose: shared constants for the timer/event counter block
// Assumes: 32-bit AXI4-Lite register bus, 16-bit counter
// Notes: register offsets are byte addresses, one aligned word each
package tec_pkg;
	// bus geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int CNT_W = 16;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_PRELOAD = 8'h04;
	localparam logic [7:0] OFS_COUNT = 8'h08;
	localparam logic [7:0] OFS_INTCTL = 8'h0C;

	// control register field positions
	localparam int CTRL_MODE_HI = 7;
	localparam int CTRL_MODE_LO = 6;
	localparam int CTRL_RUN = 4;
	localparam int CTRL_EDGE = 3;

	// interrupt control field positions
	localparam int INT_ENABLE = 0;
	localparam int INT_FLAG = 1;

	// reset values and full count
	localparam logic [1:0] MODE_RESET = 2'h0;
	localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_FULL = 16'hFFFF;

	// AXI response codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// operating mode select encodings
	typedef enum logic [1:0] {
		TEC_MODE_TIMER = 2'h0,
		TEC_MODE_EVENT = 2'h1,
		TEC_MODE_SPARE = 2'h2,
		TEC_MODE_CAPTURE = 2'h3
	} tec_mode_t;

	// pulse capture sequencer, one-hot
	typedef enum logic [2:0] {
		TEC_CAP_IDLE = 3'h1,
		TEC_CAP_ARMED = 3'h2,
		TEC_CAP_MEASURE = 3'h4
	} tec_cap_t;
endpackage

// ---- hw/tec_timer.sv ----
// Purpose: 16-bit timer/event counter with preload, capture and wake-up
// Assumes: AXI4-Lite slave on clk; powerDown comes from clk-domain logic
// Notes: ce low freezes every flop; count and preload reset to zero
`timescale 1ns/1ps
module tec_timer
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic [tec_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [tec_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [tec_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [tec_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic externalCountInput,
	input wire logic powerDown,
	output logic timerIrq,
	output logic wakeUp
);
	// control state
	tec_pkg::tec_mode_t operatingModeSelect;
	logic counterRunEnable;
	logic activeEdgeSelect;
	logic irqEnable;
	logic irqFlag;
	logic [tec_pkg::CNT_W-1:0] preload;
	logic [tec_pkg::CNT_W-1:0] count;
	tec_pkg::tec_cap_t capState;
	tec_pkg::tec_cap_t next_capState;

	// write channel holding
	logic awHeld;
	logic wHeld;
	logic [tec_pkg::ADDR_W-1:0] wrAddr;
	logic [tec_pkg::DATA_W-1:0] wrData;
	logic [3:0] wrStrb;
	logic doWrite;

	// decoded access strobes
	logic wrCtrl;
	logic wrPreload;
	logic wrIntctl;
	logic wrHit;
	logic rdTake;
	logic rdCount;

	// input view and derived events
	logic pinLevel;
	logic pinPrev;
	logic pinRise;
	logic pinFall;
	logic activeEdge;
	logic startEdge;
	logic endEdge;
	logic inhibit;
	logic tick;
	logic overflow;
	logic captureDone;
	logic runPrev;

	// input passes two flops, so it counts at a later clock
	tec_pin_sync u_sync
	(
		.clk(clk),
		.rstn(rstn),
		.ce(ce),
		.pinIn(externalCountInput),
		.level(pinLevel),
		.levelPrev(pinPrev)
	);

	// edge picture of the synchronised input
	assign pinRise = pinLevel & ~pinPrev;
	assign pinFall = ~pinLevel & pinPrev;

	// edge select picks the counted transition
	assign activeEdge = activeEdgeSelect ? pinFall : pinRise;

	// capture starts on the opposite sense of edge select
	assign startEdge = activeEdgeSelect ? pinRise : pinFall;
	assign endEdge = activeEdgeSelect ? pinFall : pinRise;

	// write happens once both address and data are in hand
	assign doWrite = awHeld & wHeld & ~s_axi_bvalid;
	assign wrCtrl = doWrite && wrAddr == tec_pkg::OFS_CTRL;
	assign wrPreload = doWrite && wrAddr == tec_pkg::OFS_PRELOAD;
	assign wrIntctl = doWrite && wrAddr == tec_pkg::OFS_INTCTL;
	assign wrHit = wrCtrl | wrPreload | wrIntctl;

	// reads are taken whenever no answer is pending
	assign s_axi_arready = ~s_axi_rvalid;
	assign rdTake = s_axi_arvalid & s_axi_arready;
	assign rdCount = rdTake && s_axi_araddr == tec_pkg::OFS_COUNT;

	// each channel is ready while its own holder is empty
	assign s_axi_awready = ~awHeld;
	assign s_axi_wready = ~wHeld;

	// address write channel holder
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			awHeld <= 1'b0;
			wrAddr <= '0;
		end
		else if (ce)
		begin
			if (s_axi_awvalid && !awHeld)
			begin
				awHeld <= 1'b1;
				wrAddr <= s_axi_awaddr;
			end
			else if (doWrite)
				awHeld <= 1'b0;
		end
	end

	// data write channel holder, independent of address order
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			wHeld <= 1'b0;
			wrData <= '0;
			wrStrb <= '0;
		end
		else if (ce)
		begin
			if (s_axi_wvalid && !wHeld)
			begin
				wHeld <= 1'b1;
				wrData <= s_axi_wdata;
				wrStrb <= s_axi_wstrb;
			end
			else if (doWrite)
				wHeld <= 1'b0;
		end
	end

	// write response; unmapped offsets answer slave error
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= tec_pkg::RESP_OKAY;
		end
		else if (ce)
		begin
			if (doWrite)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wrHit ? tec_pkg::RESP_OKAY
					: tec_pkg::RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// read data registered one cycle after the address is taken
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= tec_pkg::RESP_OKAY;
		end
		else if (ce)
		begin
			if (rdTake)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= tec_pkg::RESP_OKAY;
				s_axi_rdata <= '0;
				unique case (s_axi_araddr)
					tec_pkg::OFS_CTRL:
					begin
						s_axi_rdata[tec_pkg::CTRL_MODE_HI:
							tec_pkg::CTRL_MODE_LO] <= operatingModeSelect;
						s_axi_rdata[tec_pkg::CTRL_RUN] <= counterRunEnable;
						s_axi_rdata[tec_pkg::CTRL_EDGE] <= activeEdgeSelect;
					end
					tec_pkg::OFS_PRELOAD:
						s_axi_rdata[tec_pkg::CNT_W-1:0] <= preload;
					tec_pkg::OFS_COUNT:
						s_axi_rdata[tec_pkg::CNT_W-1:0] <= count;
					tec_pkg::OFS_INTCTL:
					begin
						s_axi_rdata[tec_pkg::INT_ENABLE] <= irqEnable;
						s_axi_rdata[tec_pkg::INT_FLAG] <= irqFlag;
					end
					default:
						s_axi_rresp <= tec_pkg::RESP_SLVERR;
				endcase
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// freeze counting while software touches the counter
	assign inhibit = rdCount | wrPreload;

	// count qualifier per operating mode
	always_comb
	begin
		tick = 1'b0;
		unique case (operatingModeSelect)
			// internal clock counts every cycle when awake
			tec_pkg::TEC_MODE_TIMER:
				tick = counterRunEnable & ~powerDown;
			tec_pkg::TEC_MODE_EVENT:
				tick = counterRunEnable & activeEdge;
			// capture counts clk only inside the pulse
			tec_pkg::TEC_MODE_CAPTURE:
				tick = counterRunEnable & ~powerDown
					& (capState == tec_pkg::TEC_CAP_MEASURE)
					& ~endEdge;
			// spare code holds the counter
			tec_pkg::TEC_MODE_SPARE:
				tick = 1'b0;
		endcase
		if (inhibit)
			tick = 1'b0;
	end

	// overflow is the step out of the full value
	assign overflow = tick && count == tec_pkg::CNT_FULL;

	// reload on overflow, else count upward
	always_ff @(posedge clk)
	begin
		if (!rstn)
			count <= tec_pkg::CNT_RESET;
		else if (ce)
		begin
			if (overflow)
				count <= preload;
			else if (tick)
				count <= count + 16'h0001;
			// stopped counter takes the preload value
			else if (wrPreload && !counterRunEnable)
			begin
				if (wrStrb[0])
					count[7:0] <= wrData[7:0];
				if (wrStrb[1])
					count[15:8] <= wrData[15:8];
			end
		end
	end

	// preload register, written per byte lane
	always_ff @(posedge clk)
	begin
		if (!rstn)
			preload <= tec_pkg::CNT_RESET;
		else if (ce && wrPreload)
		begin
			if (wrStrb[0])
				preload[7:0] <= wrData[7:0];
			if (wrStrb[1])
				preload[15:8] <= wrData[15:8];
		end
	end

	// mode and edge select fields of the control register
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			operatingModeSelect <= tec_tpl_mode(tec_pkg::MODE_RESET);
			activeEdgeSelect <= 1'b0;
		end
		// mode field sits in bits 7 and 6
		else if (ce && wrCtrl && wrStrb[0])
		begin
			operatingModeSelect <= tec_tpl_mode(
				wrData[tec_pkg::CTRL_MODE_HI:tec_pkg::CTRL_MODE_LO]);
			activeEdgeSelect <= wrData[tec_pkg::CTRL_EDGE];
		end
	end

	// cast a raw field into the mode type
	function automatic tec_pkg::tec_mode_t tec_tpl_mode(
		input logic [1:0] raw);
		tec_tpl_mode = tec_pkg::tec_mode_t'(raw);
	endfunction

	// capture ends when the input returns to its rest level
	assign captureDone = counterRunEnable
		&& operatingModeSelect == tec_pkg::TEC_MODE_CAPTURE
		&& capState == tec_pkg::TEC_CAP_MEASURE && endEdge;

	// run bit; a software write in the same cycle beats the auto clear
	always_ff @(posedge clk)
	begin
		if (!rstn)
			counterRunEnable <= 1'b0;
		else if (ce)
		begin
			// bit 4 starts and stops counting
			if (wrCtrl && wrStrb[0])
				counterRunEnable <= wrData[tec_pkg::CTRL_RUN];
			// hardware clears run at end of pulse
			else if (captureDone)
				counterRunEnable <= 1'b0;
		end
	end

	// history of run bit to spot a fresh arm
	always_ff @(posedge clk)
	begin
		if (!rstn)
			runPrev <= 1'b0;
		else if (ce)
			runPrev <= counterRunEnable;
	end

	// capture sequencer next state
	always_comb
	begin
		next_capState = capState;
		unique case (capState)
			tec_pkg::TEC_CAP_IDLE:
				if (counterRunEnable && !runPrev)
					next_capState = tec_pkg::TEC_CAP_ARMED;
			// waits for the leading edge of the pulse
			tec_pkg::TEC_CAP_ARMED:
				if (startEdge)
					next_capState = tec_pkg::TEC_CAP_MEASURE;
			tec_pkg::TEC_CAP_MEASURE:
				if (endEdge)
					next_capState = tec_pkg::TEC_CAP_IDLE;
			default:
				next_capState = tec_pkg::TEC_CAP_IDLE;
		endcase
		// stopping or leaving capture mode abandons the sequence
		if (!counterRunEnable
			|| operatingModeSelect != tec_pkg::TEC_MODE_CAPTURE)
			next_capState = tec_pkg::TEC_CAP_IDLE;
	end

	// capture sequencer state register
	always_ff @(posedge clk)
	begin
		if (!rstn)
			capState <= tec_pkg::TEC_CAP_IDLE;
		else if (ce)
			capState <= next_capState;
	end

	// interrupt enable bit
	always_ff @(posedge clk)
	begin
		if (!rstn)
			irqEnable <= 1'b0;
		else if (ce && wrIntctl && wrStrb[0])
			irqEnable <= wrData[tec_pkg::INT_ENABLE];
	end

	// request flag: overflow set wins over a software clear
	always_ff @(posedge clk)
	begin
		if (!rstn)
			irqFlag <= 1'b0;
		else if (ce)
		begin
			// every counting mode, timer included, sets the flag
			if (overflow)
				irqFlag <= 1'b1;
			// software may write the flag high itself
			else if (wrIntctl && wrStrb[0])
				irqFlag <= wrData[tec_pkg::INT_FLAG];
		end
	end

	// interrupt gated by enable; a preset flag makes no new edge
	assign timerIrq = irqFlag & irqEnable;

	// wake-up pulse needs a new request while powered down
	// a flag already high blocks it, so a preset flag prevents waking
	always_ff @(posedge clk)
	begin
		if (!rstn)
			wakeUp <= 1'b0;
		else if (ce)
			wakeUp <= overflow & powerDown & ~irqFlag;
	end
endmodule

// ---- testbench/tb.sv ----
// Purpose: register-level regression of the timer/event counter
// Assumes: ce high but for one freeze check; pin source drives pin alone
// Notes: capture width allowed one cycle of slack, pin is async
`timescale 1ns/1ps
module tb;
	localparam logic [7:0] CT = tec_pkg::OFS_CTRL;
	localparam logic [7:0] PL = tec_pkg::OFS_PRELOAD;
	localparam logic [7:0] CN = tec_pkg::OFS_COUNT;
	localparam logic [7:0] IC = tec_pkg::OFS_INTCTL;
	localparam logic [1:0] OK = tec_pkg::RESP_OKAY;
	localparam logic [1:0] ER = tec_pkg::RESP_SLVERR;
	logic clk, rstn, ce, powerDown, externalCountInput, timerIrq, wakeUp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d, d2;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int numErrors, checkCount, wakeCnt;

	tec_timer dut_u
	(
		.clk, .rstn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .externalCountInput, .powerDown,
		.timerIrq, .wakeUp
	);
	tec_pin_src src_u
	(
		.pin(externalCountInput)
	);

	// free-running 200 MHz clock
	initial
	begin
		clk = 1'b0;
		forever
			#2.5 clk = ~clk;
	end

	// wake-up pulses seen so far
	always @(posedge clk)
	begin
		if (wakeUp === 1'b1)
			wakeCnt++;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checkCount++;
		if (seen !== exp)
		begin
			numErrors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// one write; address and data offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] v,
		input logic [1:0] er);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1);
		chk(32'(s_axi_bresp), 32'(er));
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v,
		input logic [1:0] er);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1);
		v = s_axi_rdata;
		chk(32'(s_axi_rresp), 32'(er));
		s_axi_rready <= 1'b0;
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] v;
		rd(a, v, OK);
		chk(v, e);
	endtask

	task automatic finishTest;
		$display("checks %0d, errors %0d", checkCount, numErrors);
		if (numErrors == 0 && checkCount > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// hang guard of 20000 cycles, far beyond the several hundred cycles needed
	initial
	begin
		#100us;
		numErrors++;
		finishTest;
	end

	initial
	begin
		{rstn, powerDown, s_axi_awvalid, s_axi_wvalid} = 4'h0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hF;
		ce = 1'b1;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		// register map, holes answer an error
		for (int i = 0; i < 4; i++)
			rc(8'(4 * i), 0);
		rd(8'h10, d, ER);
		wr(CN, 1, ER);
		$display("test map done");
		// timer overflow, reload and flag
		wr(PL, 32'hFF00, OK);
		rc(CN, 32'hFF00);
		wr(IC, 1, OK);
		wr(CT, 32'h10, OK);
		for (int i = 0; i < 400 && timerIrq !== 1'b1; i++)
			@(posedge clk);
		chk(32'(timerIrq), 1);
		wr(CT, 0, OK);
		rd(CN, d, OK);
		chk(32'(d[15:8]), 32'hFF);
		rc(CN, d);
		rc(IC, 3);
		wr(IC, 2, OK);
		chk(32'(timerIrq), 0);
		wr(IC, 0, OK);
		$display("test timer done");
		// back-to-back counter reads lose a tick each
		wr(PL, 0, OK);
		wr(CT, 32'h10, OK);
		rd(CN, d, OK);
		rd(CN, d2, OK);
		chk(d2 - d, 2);
		// frozen by ce: only the cycles with ce high may count
		ce <= 1'b0;
		repeat (6) @(posedge clk);
		ce <= 1'b1;
		rd(CN, d, OK);
		chk(d - d2, 2);
		// spare mode code holds the counter although run is set
		wr(CT, 32'h90, OK);
		rd(CN, d, OK);
		repeat (4) @(posedge clk);
		rc(CN, d);
		wr(CT, 0, OK);
		$display("test inhibit done");
		// three pin edges: two rising, one falling
		for (int e = 0; e < 2; e++)
		begin
			wr(PL, 0, OK);
			wr(CT, 32'h50 | (e << 3), OK);
			src_u.toggles(3, 37);
			repeat (8) @(posedge clk);
			rc(CN, 2 - e);
			wr(CT, 0, OK);
			src_u.toggles(1, 37);
		end
		$display("test event done");
		// overflow while asleep wakes, unless flag preset
		wr(PL, 32'hFFFE, OK);
		wr(CT, 32'h50, OK);
		powerDown <= 1'b1;
		d = 32'(wakeCnt);
		src_u.toggles(4, 37);
		repeat (8) @(posedge clk);
		chk(32'(wakeCnt) - d, 1);
		chk(32'(timerIrq), 0);
		powerDown <= 1'b0;
		rc(IC, 2);
		wr(CT, 0, OK);
		wr(IC, 0, OK);
		wr(PL, 32'hFFFF, OK);
		wr(IC, 2, OK);
		wr(CT, 32'h50, OK);
		powerDown <= 1'b1;
		d = 32'(wakeCnt);
		src_u.toggles(2, 37);
		repeat (8) @(posedge clk);
		chk(32'(wakeCnt) - d, 0);
		powerDown <= 1'b0;
		wr(IC, 0, OK);
		$display("test wake done");
		// one 203 ns high pulse, about 40 cycles
		wr(CT, 0, OK);
		wr(PL, 0, OK);
		wr(CT, 32'hD8, OK);
		repeat (4) @(posedge clk);
		src_u.toggles(2, 203);
		repeat (8) @(posedge clk);
		rc(CT, 32'hC8);
		rd(CN, d, OK);
		chk(32'(d >= 39 && d <= 41), 1);
		src_u.toggles(2, 37);
		repeat (8) @(posedge clk);
		rc(CN, d);
		$display("test capture done");
		finishTest;
	end
endmodule

// ---- testbench/tec_pin_src.sv ----
// Purpose: outside signal source on the count pin
// Assumes: pin idles low and is always driven
// Notes: delays in ns, unrelated to clk
`timescale 1ns/1ps
module tec_pin_src
(
	output logic pin
);
	initial pin = 1'b0;

	// async pin edges
	// h chosen by caller, so edges can be fast or slow
	task automatic toggles(input int n, input int h);
		repeat (n)
		begin
			#(h) pin = ~pin;
		end
	endtask
endmodule

// ---- testbench/tec_timer_props.sv ----
// Purpose: port-level checks of the timer/event counter
// Assumes: one clock domain; bus idle while ce is low
// Notes: bound to every timer instance
`timescale 1ns/1ps
module tec_timer_props
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic powerDown,
	input wire logic timerIrq,
	input wire logic wakeUp
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	// both write halves taken at one edge
	sequence s_wtake;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rtake;
		s_axi_arvalid && s_axi_arready;
	endsequence
	property p_wr_walk;
		s_wtake |=> (!s_axi_awready && !s_axi_wready)
			##1 (s_axi_bvalid && s_axi_awready);
	endproperty
	property p_rd_walk;
		s_rtake |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	property p_b_once;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	property p_r_once;
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
	endproperty
	property p_bresp;
		s_axi_bvalid |-> s_axi_bresp == tec_pkg::RESP_OKAY
			|| s_axi_bresp == tec_pkg::RESP_SLVERR;
	endproperty
	// wake-up only after a cycle spent powered down, one pulse
	property p_wake_pd;
		wakeUp |-> $past(powerDown);
	endproperty
	property p_wake_one;
		wakeUp |=> !wakeUp;
	endproperty
	// irq drops only by a software write
	property p_irq_fall;
		$fell(timerIrq) |-> $rose(s_axi_bvalid);
	endproperty

	a_wr_walk: assert property (p_wr_walk)
		else $error("write answer mistimed");
	a_rd_walk: assert property (p_rd_walk)
		else $error("read answer mistimed");
	a_b_once: assert property (p_b_once)
		else $error("write answer repeated");
	a_r_once: assert property (p_r_once)
		else $error("read answer repeated");
	a_bresp: assert property (p_bresp)
		else $error("bad write response code");
	a_wake_pd: assert property (p_wake_pd)
		else $error("wake-up while awake");
	a_wake_one: assert property (p_wake_one)
		else $error("wake-up longer than a pulse");
	a_irq_fall: assert property (p_irq_fall)
		else $error("interrupt dropped without a write");
endmodule

bind tec_timer tec_timer_props props_u
(
	.clk, .rstn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
	.powerDown, .timerIrq, .wakeUp
);
